/* File: hw/mlsc_low_speed_ctrl.sv */
// Low-speed management and control logic of a four-lane pluggable module
//
// Notes on behaviour
// RULE_01: The serial slave only answers while module select is held low.
// RULE_02: The host gives each module its own select line so one is addressed at a time.
// RULE_03: A reset input held low longer than the minimum restores all settings.
// RULE_04: The host ignores status bits until reset completion is signalled.
// RULE_05: Reset completion raises the interrupt with the not-ready bit cleared.
// RULE_06: Power-up reset posts the completion interrupt without a reset pulse.
// RULE_07: The interrupt output goes low for faults or critical status.
// RULE_08: The host reads the flags over the serial bus to find the cause.
// RULE_09: The interrupt output is open drain and only pulls low.
// RULE_10: Loss of signal is raised when any lane power is below the threshold.
// RULE_11: The transmitter is off when the pin or the serial control asks for it.
// RULE_12: Each lane's received power is readable over the serial bus.
// RULE_13: The low-power input limits the module's power draw.
// RULE_14: The presence output pulls low once the module is in place.
// RULE_15: The host clocks the serial bus and both sides share the data line.
// RULE_16: A reset pulse shorter than the minimum length starts no reset.
`timescale 1ns/10ps
module mlsc_low_speed_ctrl #(
    parameter int          LANES         = mlsc_pkg::LANES,
    parameter int          PWR_W         = mlsc_pkg::PWR_W,
    parameter int          RESET_MIN_CYC = mlsc_pkg::RESET_MIN_CYC,
    parameter logic [6:0]  DEV_ADDR      = mlsc_pkg::DEV_ADDR
) (
    // Clock and power-up reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   reset_in,
    // Host control pins
    input  wire logic                   module_select_n_in,
    input  wire logic                   module_reset_n_in,
    input  wire logic                   low_power_request_in,
    input  wire logic                   transmit_disable_in,
    // Serial bus pins
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe_out,
    // Open-drain status pins
    output logic                        interrupt_n_out,
    output logic                        interrupt_oe_out,
    output logic                        present_n_out,
    output logic                        present_oe_out,
    // Optical monitor and fault inputs
    input  wire logic [LANES*PWR_W-1:0] rx_power_in,
    input  wire logic                   fault_in,
    // Module controls and status
    output logic                        receive_signal_lost_out,
    output logic                        transmitter_off_out,
    output logic                        low_power_active_out,
    output logic                        data_not_ready_out
);
    localparam int CNT_W = $clog2(RESET_MIN_CYC + 1);
    localparam int FW    = mlsc_pkg::FLAG_W;

    logic [3:0]                         pin_s1_q;
    logic [3:0]                         pin_s2_q;
    logic                               select_s;
    logic                               reset_n_s;
    logic                               low_power_s;
    logic                               tx_disable_s;
    logic [CNT_W-1:0]                   low_cnt_q;
    logic                               soft_start;
    logic                               core_rst;
    logic [mlsc_pkg::INIT_W-1:0]        init_cnt_q;
    logic                               not_ready_q;
    logic                               ready_pulse;
    logic [FW-1:0]                      flags_q;
    logic [FW-1:0]                      flag_set;
    logic [FW-1:0]                      flag_clr;
    logic [7:0]                         ctrl_q;
    logic [7:0]                         mask_q;
    logic [PWR_W-1:0]                   thresh_q;
    logic [LANES-1:0]                   lane_los;
    logic                               los_any_q;
    logic [7:0]                         ptr;
    logic [7:0]                         acc_addr;
    logic [7:0]                         wdata;
    logic                               wr;
    logic                               rd;
    logic [7:0]                         rdata;

    // Pin synchronisers
    always_ff @(posedge clk_sys_in) begin
        pin_s1_q <= {transmit_disable_in, low_power_request_in,
                     module_reset_n_in, module_select_n_in};
        pin_s2_q <= pin_s1_q;
    end

    assign select_s     = ~pin_s2_q[0];
    assign reset_n_s    = pin_s2_q[1];
    assign low_power_s  = pin_s2_q[2];
    assign tx_disable_s = pin_s2_q[3];

    // Reset pulse length filter
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || reset_n_s) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != CNT_W'(RESET_MIN_CYC)) begin
            low_cnt_q <= low_cnt_q + CNT_W'(1); // RULE_16
        end
    end

    assign soft_start = !reset_in && !reset_n_s &&
                        (low_cnt_q == CNT_W'(RESET_MIN_CYC - 1)); // RULE_16
    // Held in reset from power-up and while a long reset pulse stays low
    assign core_rst   = reset_in || soft_start ||
                        (low_cnt_q == CNT_W'(RESET_MIN_CYC)); // RULE_03 RULE_06

    // Reset completion sequence
    always_ff @(posedge clk_sys_in) begin
        if (core_rst) begin
            init_cnt_q  <= '0;
            not_ready_q <= 1'b1;
        end else if (not_ready_q) begin
            init_cnt_q <= init_cnt_q + mlsc_pkg::INIT_W'(1);
            if (ready_pulse) begin
                not_ready_q <= 1'b0; // RULE_05
            end
        end
    end

    assign ready_pulse = !core_rst && not_ready_q &&
        (init_cnt_q == mlsc_pkg::INIT_W'(mlsc_pkg::INIT_CYC - 1));

    // Sticky event flags, cleared by reading them; a new event wins
    assign flag_set = {fault_in, (|lane_los) & ~los_any_q, ready_pulse};
    assign flag_clr = (rd && acc_addr == mlsc_pkg::ADDR_FLAGS) ? flags_q : '0;

    always_ff @(posedge clk_sys_in) begin
        if (core_rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set; // RULE_05 RULE_07
        end
    end

    // Writable settings
    always_ff @(posedge clk_sys_in) begin
        if (core_rst) begin
            ctrl_q   <= mlsc_pkg::CTRL_RST; // RULE_03
            mask_q   <= mlsc_pkg::MASK_RST;
            thresh_q <= PWR_W'(mlsc_pkg::THRESH_RST);
        end else if (wr) begin
            if (acc_addr == mlsc_pkg::ADDR_CTRL) begin
                ctrl_q <= wdata;
            end
            if (acc_addr == mlsc_pkg::ADDR_MASK) begin
                mask_q <= wdata;
            end
            if (acc_addr == mlsc_pkg::ADDR_THRESH) begin
                thresh_q <= PWR_W'(wdata);
            end
        end
    end

    // Per-lane loss of signal
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            lane_los[i] = rx_power_in[i*PWR_W +: PWR_W] < thresh_q; // RULE_10
        end
    end

    // Memory map read data
    always_comb begin
        rdata = 8'h00;
        if (ptr == mlsc_pkg::ADDR_STATUS) begin
            rdata[mlsc_pkg::STAT_NOT_READY] = not_ready_q;
        end
        if (ptr == mlsc_pkg::ADDR_FLAGS) begin
            rdata[FW-1:0] = flags_q; // RULE_08
        end
        if (ptr == mlsc_pkg::ADDR_LOS) begin
            rdata[LANES-1:0] = lane_los;
        end
        for (int i = 0; i < LANES; i++) begin
            if (ptr == mlsc_pkg::ADDR_PWR0 + 8'(i)) begin
                rdata[PWR_W-1:0] = rx_power_in[i*PWR_W +: PWR_W]; // RULE_12
            end
        end
        if (ptr == mlsc_pkg::ADDR_CTRL) begin
            rdata = ctrl_q;
        end
        if (ptr == mlsc_pkg::ADDR_MASK) begin
            rdata = mask_q;
        end
        if (ptr == mlsc_pkg::ADDR_THRESH) begin
            rdata[PWR_W-1:0] = thresh_q;
        end
    end

    mlsc_serial_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_serial (
        .clk_sys_in   (clk_sys_in),
        .reset_in     (core_rst),
        .select_in    (select_s), // RULE_01
        .scl_in       (scl_in), // RULE_15
        .sda_in       (sda_in),
        .sda_oe_out   (sda_oe_out),
        .ptr_out      (ptr),
        .acc_addr_out (acc_addr),
        .wdata_out    (wdata),
        .wr_out       (wr),
        .rd_out       (rd),
        .rdata_in     (rdata)
    );

    // Output pins
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            interrupt_oe_out <= 1'b0;
        end else begin
            interrupt_oe_out <= |(flags_q & ~mask_q[FW-1:0]); // RULE_07
        end
    end

    always_ff @(posedge clk_sys_in) begin
        // Open-drain pins only ever drive low
        sda_out         <= 1'b0;
        interrupt_n_out <= 1'b0; // RULE_09
        present_n_out   <= 1'b0;
        if (reset_in) begin
            present_oe_out <= 1'b1; // RULE_14
        end else begin
            present_oe_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            los_any_q               <= 1'b0;
            receive_signal_lost_out <= 1'b0;
            transmitter_off_out     <= 1'b1;
            low_power_active_out    <= 1'b1;
            data_not_ready_out      <= 1'b1;
        end else begin
            los_any_q               <= |lane_los;
            receive_signal_lost_out <= |lane_los; // RULE_10
            transmitter_off_out     <= tx_disable_s | ctrl_q[mlsc_pkg::CTRL_TX_OFF]; // RULE_11
            low_power_active_out    <= low_power_s |
                                       ctrl_q[mlsc_pkg::CTRL_LOW_POWER]; // RULE_13
            data_not_ready_out      <= not_ready_q;
        end
    end

    // Checks
    localparam int READY_MAX = mlsc_pkg::INIT_CYC + 3;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    sequence s_long_low;
        !reset_n_s && (low_cnt_q == CNT_W'(RESET_MIN_CYC - 1));
    endsequence

    sequence s_ready_edge;
        not_ready_q ##1 !not_ready_q;
    endsequence

    a_filter_length: assert property ( // RULE_16
        soft_start |-> s_long_low)
        else $error("reset started before minimum low time");
    a_short_ignored: assert property ( // RULE_16
        $rose(reset_n_s) && $past(low_cnt_q) < CNT_W'(RESET_MIN_CYC - 1) |-> !core_rst)
        else $error("short reset pulse caused a reset");
    a_reset_defaults: assert property ( // RULE_03
        soft_start |=> ctrl_q == mlsc_pkg::CTRL_RST && mask_q == mlsc_pkg::MASK_RST
                       && thresh_q == PWR_W'(mlsc_pkg::THRESH_RST)
                       && not_ready_q)
        else $error("settings not restored by reset");
    a_ready_interrupt: assert property ( // RULE_05
        s_ready_edge |-> flags_q[mlsc_pkg::FLAG_DONE] ##1 interrupt_oe_out)
        else $error("completion not flagged on interrupt");
    a_powerup_ready: assert property (@(posedge clk_sys_in) // RULE_06
        $fell(reset_in) && reset_n_s |-> ##[1:READY_MAX]
            (!not_ready_q && flags_q[mlsc_pkg::FLAG_DONE]))
        else $error("no completion after power-up");
    a_interrupt_drive: assert property ( // RULE_07
        |(flags_q & ~mask_q[FW-1:0]) |=> interrupt_oe_out && !interrupt_n_out)
        else $error("unmasked event not driving interrupt low");
    a_los_follows: assert property ( // RULE_10
        (|lane_los) |=> receive_signal_lost_out)
        else $error("loss of signal not raised");
    a_tx_off: assert property ( // RULE_11
        tx_disable_s |=> transmitter_off_out)
        else $error("transmitter not turned off");
    a_tx_serial: assert property ( // RULE_11
        ctrl_q[mlsc_pkg::CTRL_TX_OFF] |=> transmitter_off_out)
        else $error("serial transmit disable ignored");
    a_fault_wins: assert property ( // RULE_07
        flag_set[mlsc_pkg::FLAG_FAULT] && !core_rst |=> flags_q[mlsc_pkg::FLAG_FAULT])
        else $error("fault event lost against a clear");
    a_status_copy: assert property ( // RULE_05
        not_ready_q |=> data_not_ready_out)
        else $error("not-ready status not shown");
    a_low_power: assert property ( // RULE_13
        low_power_s |=> low_power_active_out)
        else $error("low power request ignored");
    a_present_low: assert property ( // RULE_14
        ##1 (present_oe_out && !present_n_out))
        else $error("presence not pulled low");
endmodule

/* File: hw/mlsc_pkg.sv */
// Shared constants and types for the module low-speed control block
package mlsc_pkg;
    // Clock and timing
    localparam int CLK_MHZ       = 250;
    localparam int RESET_MIN_NS  = 2000;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int INIT_CYC      = 16;
    localparam int INIT_W        = 5;

    // Lanes and monitor words
    localparam int LANES = 4;
    localparam int PWR_W = 8;

    // Serial bus device address, value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2a;

    // Memory map byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_FLAGS  = 8'h01;
    localparam logic [7:0] ADDR_LOS    = 8'h02;
    localparam logic [7:0] ADDR_PWR0   = 8'h03;
    localparam logic [7:0] ADDR_CTRL   = 8'h07;
    localparam logic [7:0] ADDR_MASK   = 8'h08;
    localparam logic [7:0] ADDR_THRESH = 8'h09;

    // Field positions
    localparam int STAT_NOT_READY = 0;
    localparam int FLAG_DONE      = 0;
    localparam int FLAG_LOS       = 1;
    localparam int FLAG_FAULT     = 2;
    localparam int FLAG_W         = 3;
    localparam int CTRL_TX_OFF    = 0;
    localparam int CTRL_LOW_POWER = 1;

    // Reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic [7:0] THRESH_RST = 8'h10;

    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_WRITE,
        ST_ACK_WRITE,
        ST_READ,
        ST_ACK_READ
    } mlsc_ser_state_e;
endpackage

/* File: hw/mlsc_serial_slave.sv */
// Two-wire serial slave giving byte access to the memory map
`timescale 1ns/10ps
module mlsc_serial_slave #(
    parameter logic [6:0] DEV_ADDR = mlsc_pkg::DEV_ADDR
) (
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    // Gate from module select, high when selected
    input  wire logic       select_in,
    // Serial pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_oe_out,
    // Memory map access
    output logic [7:0]      ptr_out,
    output logic [7:0]      acc_addr_out,
    output logic [7:0]      wdata_out,
    output logic            wr_out,
    output logic            rd_out,
    input  wire logic [7:0] rdata_in
);
    logic [1:0]                scl_sync_q;
    logic [1:0]                sda_sync_q;
    logic                      scl_q;
    logic                      sda_q;
    mlsc_pkg::mlsc_ser_state_e state_q;
    logic [7:0]                shift_q;
    logic [2:0]                bits_q;
    logic                      done_q;
    logic                      rw_q;
    logic                      first_q;
    logic                      acked_q;
    logic                      scl_rise;
    logic                      scl_fall;
    logic                      start_seen;
    logic                      stop_seen;

    always_ff @(posedge clk_sys_in) begin
        scl_sync_q <= {scl_sync_q[0], scl_in};
        sda_sync_q <= {sda_sync_q[0], sda_in};
        scl_q      <= scl_sync_q[1];
        sda_q      <= sda_sync_q[1];
    end

    assign scl_rise   = scl_sync_q[1] & ~scl_q;
    assign scl_fall   = ~scl_sync_q[1] & scl_q;
    assign start_seen = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
    assign stop_seen  = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];

    always_ff @(posedge clk_sys_in) begin
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        if (reset_in || !select_in) begin
            state_q    <= mlsc_pkg::ST_IDLE; // RULE_01
            sda_oe_out <= 1'b0;
            bits_q     <= 3'h0;
            done_q     <= 1'b0;
            if (reset_in) begin
                ptr_out      <= 8'h00;
                acc_addr_out <= 8'h00;
                wdata_out    <= 8'h00;
                shift_q      <= 8'h00;
                rw_q         <= 1'b0;
                first_q      <= 1'b0;
                acked_q      <= 1'b0;
            end
        end else if (start_seen) begin
            state_q    <= mlsc_pkg::ST_ADDR;
            sda_oe_out <= 1'b0;
            bits_q     <= 3'h0;
            done_q     <= 1'b0;
        end else if (stop_seen) begin
            state_q    <= mlsc_pkg::ST_IDLE;
            sda_oe_out <= 1'b0;
        end else if (scl_rise) begin
            unique case (state_q)
                mlsc_pkg::ST_ADDR, mlsc_pkg::ST_WRITE: begin
                    shift_q <= {shift_q[6:0], sda_sync_q[1]};
                    bits_q  <= bits_q + 3'h1;
                    done_q  <= (bits_q == 3'h7);
                end
                mlsc_pkg::ST_READ: begin
                    bits_q <= bits_q + 3'h1;
                    done_q <= (bits_q == 3'h7);
                end
                mlsc_pkg::ST_ACK_READ: acked_q <= ~sda_sync_q[1];
                mlsc_pkg::ST_IDLE, mlsc_pkg::ST_ACK_ADDR, mlsc_pkg::ST_ACK_WRITE: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state_q)
                mlsc_pkg::ST_ADDR: if (done_q) begin
                    done_q <= 1'b0;
                    if (shift_q[7:1] == DEV_ADDR) begin
                        state_q    <= mlsc_pkg::ST_ACK_ADDR;
                        sda_oe_out <= 1'b1;
                        rw_q       <= shift_q[0];
                        first_q    <= 1'b1;
                    end else begin
                        state_q <= mlsc_pkg::ST_IDLE;
                    end
                end
                mlsc_pkg::ST_ACK_ADDR, mlsc_pkg::ST_ACK_READ: begin
                    if ((state_q == mlsc_pkg::ST_ACK_ADDR && rw_q) ||
                        (state_q == mlsc_pkg::ST_ACK_READ && acked_q)) begin
                        // Load next byte; the read strobe names the byte being loaded
                        state_q      <= mlsc_pkg::ST_READ;
                        shift_q      <= rdata_in;
                        sda_oe_out   <= ~rdata_in[7];
                        acc_addr_out <= ptr_out;
                        rd_out       <= 1'b1;
                        ptr_out      <= ptr_out + 8'h01;
                    end else begin
                        state_q    <= (state_q == mlsc_pkg::ST_ACK_ADDR) ?
                                      mlsc_pkg::ST_WRITE : mlsc_pkg::ST_IDLE;
                        sda_oe_out <= 1'b0;
                    end
                end
                mlsc_pkg::ST_WRITE: if (done_q) begin
                    done_q     <= 1'b0;
                    state_q    <= mlsc_pkg::ST_ACK_WRITE;
                    sda_oe_out <= 1'b1;
                    first_q    <= 1'b0;
                    if (first_q) begin
                        ptr_out <= shift_q;
                    end else begin
                        wr_out       <= 1'b1;
                        acc_addr_out <= ptr_out;
                        wdata_out    <= shift_q;
                        ptr_out      <= ptr_out + 8'h01;
                    end
                end
                mlsc_pkg::ST_ACK_WRITE: begin
                    state_q    <= mlsc_pkg::ST_WRITE;
                    sda_oe_out <= 1'b0;
                end
                mlsc_pkg::ST_READ: begin
                    if (done_q) begin
                        done_q     <= 1'b0;
                        state_q    <= mlsc_pkg::ST_ACK_READ;
                        sda_oe_out <= 1'b0;
                    end else begin
                        shift_q    <= {shift_q[6:0], 1'b0};
                        sda_oe_out <= ~shift_q[6];
                    end
                end
                mlsc_pkg::ST_IDLE: begin
                end
            endcase
        end
    end

    a_deselect_quiet: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE_01
        !select_in |=> !sda_oe_out && !wr_out && !rd_out)
        else $error("serial slave active while deselected");
endmodule

/* File: tb/mlsc_host_model.sv */
// Host controller model driving the two-wire bus and the select line
`timescale 1ns/10ps
module mlsc_host_model (
    // Bus wires and select line
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out,
    output logic      select_n_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        select_n_out = 1'b1;
    end
    // One clock pulse, data set while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_low_out = ~b;
        #16 scl_out = 1'b1;
        #16 r = sda_in;
        #16 scl_out = 1'b0;
        #16;
    endtask
    task automatic start();
        sda_low_out = 1'b0;
        #16 scl_out = 1'b1;
        #32 sda_low_out = 1'b1;
        #32 scl_out = 1'b0;
        #16;
    endtask
    task automatic stop();
        sda_low_out = 1'b1;
        #16 scl_out = 1'b1;
        #32 sda_low_out = 1'b0;
        #32;
    endtask
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(1'b1, ack);
    endtask
    // Pointer write, then one data byte or a repeated start and one read byte
    task automatic access(input logic sel, input logic wr, input logic [7:0] ptr,
                          input logic [7:0] wd, output logic [7:0] rd, output logic ack);
        logic [7:0] d;
        logic       a;
        select_n_out = ~sel;
        start();
        byte_io({mlsc_pkg::DEV_ADDR, 1'b0}, d, ack);
        byte_io(ptr, d, a);
        rd = d;
        if (wr) begin
            byte_io(wd, d, a);
        end else begin
            start();
            byte_io({mlsc_pkg::DEV_ADDR, 1'b1}, d, a);
            byte_io(8'hff, rd, a);
        end
        stop();
        select_n_out = 1'b1;
    endtask
endmodule

/* File: tb/test_mlsc_low_speed_ctrl.sv */
// Self-checking bench for the low-speed control block
`timescale 1ns/10ps
module test_mlsc_low_speed_ctrl;
    localparam int RMIN = 8;
    logic        clk_sys_in, reset_in, mrst_n, lp_req, transmit_disable, fault_in;
    logic [31:0] rx_power_in;
    logic        sda_out, sda_oe, int_n, int_oe, prs_n, prs_oe;
    logic        los, tx_off, lp_act, not_ready, scl, sda_low, sel_n;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          cyc = 0;
    wire logic   sda_wire = ~(sda_low | (sda_oe & ~sda_out));
    wire logic   int_wire = int_oe ? int_n : 1'b1;
    wire logic   prs_wire = prs_oe ? prs_n : 1'b1;
    mlsc_low_speed_ctrl #(.RESET_MIN_CYC(RMIN)) i_mlsc_low_speed_ctrl (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .module_select_n_in(sel_n),
        .module_reset_n_in(mrst_n), .low_power_request_in(lp_req),
        .transmit_disable_in(transmit_disable), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe_out(sda_oe), .interrupt_n_out(int_n), .interrupt_oe_out(int_oe),
        .present_n_out(prs_n), .present_oe_out(prs_oe), .rx_power_in(rx_power_in),
        .fault_in(fault_in), .receive_signal_lost_out(los), .transmitter_off_out(tx_off),
        .low_power_active_out(lp_act), .data_not_ready_out(not_ready));
    mlsc_host_model i_mlsc_host_model (.sda_in(sda_wire), .scl_out(scl),
        .sda_low_out(sda_low), .select_n_out(sel_n));
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic acc(input logic sel, input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] r;
        logic       k;
        tick(1);
        i_mlsc_host_model.access(sel, w, a, d, r, k);
        cmp8("address ack", {7'h00, ~sel}, {7'h00, k});
        if (!w) cmp8("read data", exp, r);
        tick(1);
    endtask
    // Status is not trusted until not-ready clears
    task automatic wait_ready();
        for (int i = 0; i < 200 && not_ready !== 1'b0; i++) tick(1);
        tick(2);
    endtask
    initial begin
        reset_in = 1'b1;
        mrst_n = 1'b1;
        lp_req = 1'b0;
        transmit_disable = 1'b0;
        fault_in = 1'b0;
        rx_power_in = {4{8'h40}};
        tick(4);
        cmp8("present", 8'h00, prs_wire);
        reset_in = 1'b0;
        wait_ready();
        cmp8("power-up interrupt", 8'h00, int_wire);
        cmp8("tx off", 8'h00, tx_off);
        acc(1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
        acc(1'b1, 1'b0, 8'h01, 8'h00, 8'h01);
        cmp8("interrupt released", 8'h01, int_wire);
        acc(1'b1, 1'b1, 8'h07, 8'h01, 8'h00);
        cmp8("tx off serial", 8'h01, tx_off);
        acc(1'b1, 1'b0, 8'h07, 8'h00, 8'h01);
        acc(1'b1, 1'b1, 8'h07, 8'h00, 8'h00);
        transmit_disable = 1'b1;
        lp_req = 1'b1;
        tick(4);
        cmp8("tx off pin", 8'h01, tx_off);
        cmp8("low power pin", 8'h01, lp_act);
        transmit_disable = 1'b0;
        lp_req = 1'b0;
        tick(4);
        cmp8("tx on", 8'h00, tx_off);
        cmp8("low power off", 8'h00, lp_act);
        rx_power_in[23:16] = 8'h0f;
        tick(3);
        cmp8("signal lost", 8'h01, los);
        cmp8("los interrupt", 8'h00, int_wire);
        acc(1'b1, 1'b0, 8'h02, 8'h00, 8'h04);
        acc(1'b1, 1'b0, 8'h05, 8'h00, 8'h0f);
        acc(1'b1, 1'b0, 8'h01, 8'h00, 8'h02);
        rx_power_in[23:16] = 8'h10;
        tick(3);
        cmp8("signal back", 8'h00, los);
        fault_in = 1'b1;
        tick(1);
        fault_in = 1'b0;
        tick(2);
        cmp8("fault interrupt", 8'h00, int_wire);
        acc(1'b1, 1'b0, 8'h01, 8'h00, 8'h04);
        acc(1'b0, 1'b0, 8'h00, 8'h00, 8'hff);
        acc(1'b1, 1'b1, 8'h07, 8'h02, 8'h00);
        cmp8("low power serial", 8'h01, lp_act);
        acc(1'b1, 1'b1, 8'h08, 8'h06, 8'h00);
        acc(1'b1, 1'b1, 8'h09, 8'h50, 8'h00);
        tick(3);
        cmp8("threshold los", 8'h01, los);
        fault_in = 1'b1;
        tick(1);
        fault_in = 1'b0;
        tick(2);
        cmp8("masked interrupt", 8'h01, int_wire);
        acc(1'b1, 1'b0, 8'h01, 8'h00, 8'h06);
        mrst_n = 1'b0;
        tick(RMIN - 4);
        mrst_n = 1'b1;
        tick(20);
        cmp8("short pulse", 8'h00, not_ready);
        acc(1'b1, 1'b0, 8'h07, 8'h00, 8'h02);
        mrst_n = 1'b0;
        tick(RMIN + 12);
        cmp8("in reset", 8'h01, not_ready);
        mrst_n = 1'b1;
        wait_ready();
        cmp8("reset done interrupt", 8'h00, int_wire);
        acc(1'b1, 1'b0, 8'h07, 8'h00, 8'h00);
        acc(1'b1, 1'b0, 8'h09, 8'h00, 8'h10);
        acc(1'b1, 1'b0, 8'h08, 8'h00, 8'h00);
        conclude();
    end
endmodule
